//--- design/oscc_top.sv
// oscillator control register with apb slave, unlock key and clock dividers
// assumes apb master on ref_clk; cfg_* straps steady for two edges before reset release
//
// The APB register port and the register offsets are this design's own decisions.
`default_nettype none
`include "oscc_consts.svh"
module oscc_top #(
  parameter logic [31:0] KEY1 = `OSCC_KEY1,
  parameter logic [31:0] KEY2 = `OSCC_KEY2,
  parameter logic [15:0] SECONDARY_OSCILLATOR_WARM = `OSCC_SECONDARY_OSCILLATOR_WARM
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfg_pll_output_divider,
  input wire logic [2:0] cfg_pll_multiplier,
  input wire logic [1:0] cfg_periph_clk_divisor,
  input wire logic [2:0] cfg_new_osc_select,
  input wire logic cfg_secondary_osc_enable,
  input wire logic secondary_oscillator_running,
  output logic pll_out_tick,
  output logic fast_rc_tick,
  output logic peripheral_bus_clock_tick,
  output logic [2:0] pll_multiplier,
  output logic [2:0] new_osc_select,
  output logic secondary_osc_enable
);
  import oscc_pkg::*;

  // one compare shared by bus decode and read mux
  function automatic logic at_off(input logic [11:0] a, input logic [11:0] off);
    return (a == off);
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic acc;
  logic wr;
  logic hit_ctrl;
  logic hit_key;
  logic hit_stat;

  assign pready = 1'b1;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit_ctrl = at_off(paddr, `OSCC_OFF_CTRL);
  assign hit_key = at_off(paddr, `OSCC_OFF_KEY);
  assign hit_stat = at_off(paddr, `OSCC_OFF_STAT);
  assign pslverr = acc && !(hit_ctrl || hit_key || hit_stat);

  // ------------------------------------------------------------
  // secondary_oscillator_running pin synchroniser
  // ------------------------------------------------------------
  logic secondary_oscillator_s1_q;
  logic secondary_oscillator_s2_q;
  logic strap_done_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      secondary_oscillator_s1_q <= 1'b0;
      secondary_oscillator_s2_q <= 1'b0;
    end else begin
      secondary_oscillator_s1_q <= secondary_oscillator_running;
      secondary_oscillator_s2_q <= secondary_oscillator_s1_q;
    end
  end

  // ------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------
  // no reset so the straps settle while reset is held; they are quasi-static,
  // a strap that moves near reset release may load a mix of old and new bits
  logic [11:0] strap_s1_q;
  logic [11:0] strap_s2_q;

  always_ff @(posedge ref_clk) begin
    strap_s1_q <= {cfg_pll_output_divider, cfg_pll_multiplier, cfg_periph_clk_divisor,
      cfg_new_osc_select, cfg_secondary_osc_enable};
    strap_s2_q <= strap_s1_q;
  end

  // ------------------------------------------------------------
  // unlock sequence
  // ------------------------------------------------------------
  oscc_unlock_t ul_q;
  oscc_unlock_t ul_d;

  always_comb begin
    ul_d = ul_q;
    if (wr && hit_key) begin
      if (pwdata == KEY1) begin
        ul_d = OSCC_HALF;
      end else if (pwdata == KEY2 && ul_q == OSCC_HALF) begin
        ul_d = OSCC_OPEN;
      end else begin
        ul_d = OSCC_LOCKED;
      end
    end else if (wr && hit_ctrl) begin
      // window is single shot: any control write closes it
      ul_d = OSCC_LOCKED;
    end else if (wr) begin
      ul_d = OSCC_LOCKED;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ul_q <= OSCC_LOCKED;
    end else begin
      ul_q <= ul_d;
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  logic [2:0] plldiv_q;
  logic [2:0] plldiv_d;
  logic [2:0] fast_rc_divider_q;
  logic [2:0] fast_rc_divider_d;
  logic [1:0] periph_clk_divisor_q;
  logic [1:0] periph_clk_divisor_d;
  logic [2:0] mult_q;
  logic [2:0] mult_d;
  logic [2:0] new_osc_select_q;
  logic [2:0] new_osc_select_d;
  logic secondary_osc_enable_q;
  logic secondary_osc_enable_d;
  logic [3:0] pbwait_q;
  logic [3:0] pbwait_d;
  logic [15:0] warm_q;
  logic [15:0] warm_d;
  logic ctrl_wr;
  logic pb_ready;

  // writes only through an open window
  assign ctrl_wr = wr && hit_ctrl && (ul_q == OSCC_OPEN);
  assign pb_ready = (pbwait_q == 4'h0);

  always_comb begin
    plldiv_d = plldiv_q;
    fast_rc_divider_d = fast_rc_divider_q;
    periph_clk_divisor_d = periph_clk_divisor_q;
    mult_d = mult_q;
    new_osc_select_d = new_osc_select_q;
    secondary_osc_enable_d = secondary_osc_enable_q;
    pbwait_d = (pbwait_q != 4'h0) ? pbwait_q - 4'h1 : 4'h0;
    // straps load one cycle after every reset release
    if (!strap_done_q) begin
      plldiv_d = strap_s2_q[11:9];
      periph_clk_divisor_d = strap_s2_q[5:4];
      mult_d = strap_s2_q[8:6];
      new_osc_select_d = strap_s2_q[3:1];
      secondary_osc_enable_d = strap_s2_q[0];
    end else if (ctrl_wr) begin
      plldiv_d = pwdata[`OSCC_POS_PLL_OUTPUT_DIVIDER +: 3];
      fast_rc_divider_d = pwdata[`OSCC_POS_FAST_RC_DIVIDER +: 3];
      mult_d = pwdata[`OSCC_POS_PLL_MULTIPLIER +: 3];
      new_osc_select_d = pwdata[`OSCC_POS_NEW_OSC_SELECT +: 3];
      secondary_osc_enable_d = pwdata[`OSCC_POS_SECONDARY_OSC_ENABLE];
      if (pb_ready && pwdata[`OSCC_POS_PERIPH_CLK_DIVISOR +: 2] != periph_clk_divisor_q) begin
        periph_clk_divisor_d = pwdata[`OSCC_POS_PERIPH_CLK_DIVISOR +: 2];
        pbwait_d = `OSCC_PB_SETTLE;
      end
    end
    // warm-up count restarts whenever the oscillator stops
    if (!secondary_osc_enable_q || !secondary_oscillator_s2_q) begin
      warm_d = 16'h0000;
    end else if (warm_q != SECONDARY_OSCILLATOR_WARM) begin
      warm_d = warm_q + 16'h0001;
    end else begin
      warm_d = warm_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
      plldiv_q <= 3'h0;
      fast_rc_divider_q <= `OSCC_RST_FAST_RC_DIVIDER;
      periph_clk_divisor_q <= 2'h3;
      mult_q <= 3'h0;
      new_osc_select_q <= 3'h0;
      secondary_osc_enable_q <= 1'b0;
      pbwait_q <= 4'h0;
      warm_q <= 16'h0000;
    end else begin
      strap_done_q <= 1'b1;
      plldiv_q <= plldiv_d;
      fast_rc_divider_q <= fast_rc_divider_d;
      periph_clk_divisor_q <= periph_clk_divisor_d;
      mult_q <= mult_d;
      new_osc_select_q <= new_osc_select_d;
      secondary_osc_enable_q <= secondary_osc_enable_d;
      pbwait_q <= pbwait_d;
      warm_q <= warm_d;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic secondary_oscillator_ready;

  assign secondary_oscillator_ready = (warm_q == SECONDARY_OSCILLATOR_WARM);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`OSCC_POS_PLL_OUTPUT_DIVIDER +: 3] = plldiv_q;
    ctrl_word[`OSCC_POS_FAST_RC_DIVIDER +: 3] = fast_rc_divider_q;
    ctrl_word[`OSCC_POS_SECONDARY_OSC_READY] = secondary_oscillator_ready;
    ctrl_word[`OSCC_POS_PBRDY] = pb_ready;
    ctrl_word[`OSCC_POS_PERIPH_CLK_DIVISOR +: 2] = periph_clk_divisor_q;
    ctrl_word[`OSCC_POS_PLL_MULTIPLIER +: 3] = mult_q;
    ctrl_word[`OSCC_POS_NEW_OSC_SELECT +: 3] = new_osc_select_q;
    ctrl_word[`OSCC_POS_SECONDARY_OSC_ENABLE] = secondary_osc_enable_q;
  end

  // read data registered at the setup cycle so it is ready in access phase
  // zero is loaded at the access edge, so the bus idles at zero afterwards
  always_comb begin
    rd_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        rd_d = ctrl_word;
      end else if (hit_stat) begin
        rd_d = {30'h0, ul_q};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign prdata = rd_q;

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  // pll output divider
  oscc_clk_div #(.CW(3)) u_pll_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .code(plldiv_q),
    .tick(pll_out_tick)
  );

  oscc_clk_div #(.CW(3)) u_frc_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .code(fast_rc_divider_q),
    .tick(fast_rc_tick)
  );

  oscc_clk_div #(.CW(2)) u_pb_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .code(periph_clk_divisor_q),
    .tick(peripheral_bus_clock_tick)
  );

  assign pll_multiplier = mult_q;
  assign new_osc_select = new_osc_select_q;
  assign secondary_osc_enable = secondary_osc_enable_q;
endmodule
`default_nettype wire

//--- design/oscc_consts.svh
// oscillator control block: offsets, field positions, reset values
// assumes inclusion by bare name from design files and from the bench
`ifndef OSCC_CONSTS_SVH
`define OSCC_CONSTS_SVH

`define OSCC_OFF_CTRL 12'h000
`define OSCC_OFF_KEY 12'h004
`define OSCC_OFF_STAT 12'h008

`define OSCC_POS_PLL_OUTPUT_DIVIDER 27
`define OSCC_POS_FAST_RC_DIVIDER 24
`define OSCC_POS_SECONDARY_OSC_READY 22
`define OSCC_POS_PBRDY 21
`define OSCC_POS_PERIPH_CLK_DIVISOR 19
`define OSCC_POS_PLL_MULTIPLIER 16
`define OSCC_POS_NEW_OSC_SELECT 8
`define OSCC_POS_SECONDARY_OSC_ENABLE 1

`define OSCC_RST_FAST_RC_DIVIDER 3'h1
`define OSCC_KEY1 32'hAA99_6655
`define OSCC_KEY2 32'h5566_99AA
`define OSCC_PB_SETTLE 4'h8
`define OSCC_SECONDARY_OSCILLATOR_WARM 16'h0400

`endif

//--- design/oscc_pkg.sv
// oscillator control block: shared types
// assumes nothing of its surroundings
`default_nettype none
package oscc_pkg;
  typedef enum logic [1:0] {
    OSCC_LOCKED = 2'b00,
    OSCC_HALF = 2'b01,
    OSCC_OPEN = 2'b10
  } oscc_unlock_t;
endpackage
`default_nettype wire

//--- design/oscc_clk_div.sv
// power-of-two clock divider with selectable ratio, emits a tick per period
// assumes the ratio code is stable or changes only between periods
`default_nettype none
module oscc_clk_div #(
  parameter int CW = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [CW-1:0] code,
  output logic tick
);
  // ------------------------------------------------------------
  // divider counter
  // ------------------------------------------------------------
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] lim;

  // codes up to 6 divide by 2**code, code 7 divides by 256
  // compared at eight bits so a two-bit code 3 is not taken for 7
  always_comb begin
    if (8'(code) == 8'h07) begin
      lim = 8'hFF;
    end else begin
      lim = 8'((9'h001 << code) - 9'h001);
    end
    if (cnt_q >= lim) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q >= lim);
endmodule
`default_nettype wire

//--- dv/oscc_props.sv
// concurrent checks on the oscillator control block ports
// assumes bind into oscc_top, one clock, async active-low reset
`default_nettype none
module oscc_props #(
  parameter logic [31:0] KEY2 = 32'h5566_99AA
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [2:0] pll_multiplier,
  input wire logic [2:0] new_osc_select,
  input wire logic secondary_osc_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc, rd_ctl, key_q, key_d;
  assign acc = psel && penable;
  assign rd_ctl = acc && !pwrite && paddr == 12'h000;
  // a necessary condition only: the key alone does not prove the window open
  always_comb begin
    key_d = key_q;
    if (acc && pwrite) key_d = paddr == 12'h004 && pwdata == KEY2;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) key_q <= 1'h0;
    else key_q <= key_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // --------------------
  // register access checks
  // --------------------
  // reserved bits 31:30, 23, 15 and 11 zero
  AST_RSV: assert property (rd_ctl |-> prdata[31:30] == 2'h0 && !prdata[23]
    && !prdata[15] && !prdata[11]) else $error("reserved control bit read as one");
  AST_SECONDARY_OSCILLATOR: assert property (rd_ctl && prdata[22] |-> secondary_osc_enable)
    else $error("oscillator ready without enable");
  AST_FLD: assert property (rd_ctl |-> prdata[18:16] == pll_multiplier
    && prdata[10:8] == new_osc_select && prdata[1] == secondary_osc_enable)
    else $error("control fields differ from outputs");
  AST_LOCK: assert property (acc && pwrite && paddr == 12'h000 && !key_q
    |=> $stable(pll_multiplier) && $stable(new_osc_select) && $stable(secondary_osc_enable))
    else $error("unkeyed control write took effect");
  AST_ERR: assert property (acc && paddr > 12'h008 |-> pslverr)
    else $error("unmapped access without error");
  AST_IDLE: assert property (!psel |-> prdata == 32'h0000_0000)
    else $error("read data not cleared when idle");
  AST_KEYRD: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("key register reads nonzero");
  AST_STAT: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[31:2] == 30'h0)
    else $error("status upper bits nonzero");
endmodule
bind oscc_top oscc_props #(.KEY2(KEY2)) u_props (.ref_clk(ref_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .pll_multiplier(pll_multiplier),
  .new_osc_select(new_osc_select), .secondary_osc_enable(secondary_osc_enable));
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the oscillator control block
// assumes straps held steady and a short oscillator warm-up count
`default_nettype none
`include "oscc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MSK = 32'hFFFF_8F02;
  localparam logic [31:0] RST = 32'h113D_0602;
  localparam logic [31:0] LCK = 32'h0039_0100;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, secondary_oscillator_running, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] pll_multiplier, new_osc_select;
  logic [1:0] cfg_pb;
  logic secondary_osc_enable;
  wire [2:0] tk;
  int n_errors, checks;
  oscc_top #(.SECONDARY_OSCILLATOR_WARM(16'h0008)) dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_pll_output_divider(3'h2),
    .cfg_pll_multiplier(3'h5), .cfg_periph_clk_divisor(cfg_pb), .cfg_new_osc_select(3'h6),
    .cfg_secondary_osc_enable(1'h1), .secondary_oscillator_running(secondary_oscillator_running), .pll_out_tick(tk[0]),
    .fast_rc_tick(tk[1]), .peripheral_bus_clock_tick(tk[2]),
    .pll_multiplier(pll_multiplier), .new_osc_select(new_osc_select),
    .secondary_osc_enable(secondary_osc_enable));
  // ------------
  // bus helpers
  // ------------
  function automatic logic [31:0] cv(input logic [2:0] po, fr, input logic [1:0] pb,
    input logic [2:0] mu, no, input logic se);
    return {2'h0, po, fr, 3'h0, pb, mu, 5'h0, no, 6'h0, se, 1'h0};
  endfunction
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // psel stays high so back-to-back transfers fit the divisor settle time
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      n_errors++;
      wrap_up;
    end
    rdv = prdata;
    errv = pslverr;
  endtask
  task rel;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task unl;
    xfer(1'h1, 12'h004, `OSCC_KEY1);
    xfer(1'h1, 12'h004, `OSCC_KEY2);
  endtask
  // first period after a ratio change may be short, so skip it
  task automatic per(input int s, input int e);
    int n, k;
    n = 0;
    k = 0;
    while (k < 3 && n < 600) begin
      @(posedge ref_clk);
      n++;
      if (tk[s] === 1'h1) begin
        k++;
        if (k < 3) n = 0;
      end
    end
    if (k < 3) begin
      n_errors++;
      wrap_up;
    end
    chk(n, e);
  endtask
  // ----------
  // scenarios
  // ----------
  task t_reset;
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk(rdv & MSK, RST);
    per(1, 2);
    per(2, 8);
  endtask
  task t_lock;
    xfer(1'h1, 12'h000, LCK);
    xfer(1'h1, 12'h004, `OSCC_KEY1);
    xfer(1'h0, 12'h008, 32'h0);
    chk(rdv, 32'h1);
    xfer(1'h1, 12'h008, 32'h0);
    xfer(1'h1, 12'h004, `OSCC_KEY2);
    xfer(1'h1, 12'h000, LCK);
    xfer(1'h0, 12'h000, 32'h0);
    chk(rdv & MSK, RST);
    unl;
    xfer(1'h1, 12'h000, LCK | 32'hC080_8800);
    xfer(1'h1, 12'h000, RST);
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk(rdv & MSK, LCK);
  endtask
  task t_div;
    for (int c = 0; c < 8; c++) begin
      unl;
      xfer(1'h1, 12'h000, cv(c[2:0], c[2:0], 2'h3, 3'h5, 3'h6, 1'h1));
      rel;
      per(0, c == 7 ? 256 : 1 << c);
      per(1, c == 7 ? 256 : 1 << c);
    end
  endtask
  task t_pb;
    for (int c = 0; c < 4; c++) begin
      unl;
      xfer(1'h1, 12'h000, cv(3'h0, 3'h1, c[1:0], 3'h5, 3'h6, 1'h1));
      xfer(1'h0, 12'h000, 32'h0);
      rel;
      chk({31'h0, rdv[21]}, 32'h0);
      per(2, 1 << c);
    end
    unl;
    xfer(1'h1, 12'h000, cv(3'h0, 3'h1, 2'h0, 3'h5, 3'h6, 1'h1));
    unl;
    xfer(1'h1, 12'h000, cv(3'h0, 3'h1, 2'h2, 3'h2, 3'h6, 1'h1));
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk(rdv & 32'h001F_0000, 32'h0002_0000);
    per(2, 1);
  endtask
  task t_secondary_oscillator;
    secondary_oscillator_running <= 1'h1;
    repeat (3) @(posedge ref_clk);
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk({31'h0, rdv[22]}, 32'h0);
    repeat (12) @(posedge ref_clk);
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk({31'h0, rdv[22]}, 32'h1);
    secondary_oscillator_running <= 1'h0;
    repeat (4) @(posedge ref_clk);
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk({31'h0, rdv[22]}, 32'h0);
  endtask
  task t_err;
    xfer(1'h0, 12'h00C, 32'h0);
    chk({31'h0, errv}, 32'h1);
    xfer(1'h0, 12'h004, 32'h0);
    rel;
    chk(rdv, 32'h0);
    chk({31'h0, errv}, 32'h0);
  endtask
  // mid-run reset with a new divisor strap; strap settles while reset is held
  task t_strap;
    cfg_pb <= 2'h1;
    resetn <= 1'h0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (2) @(posedge ref_clk);
    xfer(1'h0, 12'h000, 32'h0);
    rel;
    chk(rdv & MSK, 32'h112D_0602);
    per(2, 2);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    secondary_oscillator_running = 1'h0;
    cfg_pb = 2'h3;
    n_errors = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (2) @(posedge ref_clk);
    t_reset;
    t_lock;
    t_div;
    t_pb;
    t_secondary_oscillator;
    t_err;
    t_strap;
    wrap_up;
  end
endmodule
`default_nettype wire
